// file: pkg/dpc_pkg.sv
// Shared constants and types of the defective pixel corrector
`default_nettype none
package dpc_pkg;
    localparam int PIX_W = 10;
    localparam int COORD_W = 12;
    localparam int MAX_ENTRIES = 16;
    localparam int SEL_W = 4;
    localparam int CNT_W = 5;
    localparam int NV_W = 2 * COORD_W;
    localparam int WIN = 5;
    localparam int WIN_C = 2;
    localparam int LB_ROWS = WIN - 1;
    localparam int ADDR_W = 8;

    // Count of usable entries and the non-volatile word that holds it
    localparam logic [CNT_W-1:0] MAX_COUNT = 5'h10;
    localparam logic [CNT_W-1:0] NV_LAST = 5'h10;
    localparam logic [COORD_W-1:0] WIN_MID = 12'h002;

    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] SEL_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] COLUMN_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] ROW_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] CMD_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] ACTIVE_OFS = 8'h18;

    localparam int TABLE_EN_BIT = 0;
    localparam int OUTLIER_EN_BIT = 1;
    localparam int METHOD_LSB = 4;
    localparam int METHOD_W = 2;
    localparam int CMD_COMMIT_BIT = 0;
    localparam int CMD_PERSIST_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LOADED_BIT = 1;

    localparam logic [METHOD_W-1:0] METHOD_AVERAGE = 2'h0;
    localparam logic TABLE_EN_RESET = 1'b0;
    localparam logic OUTLIER_EN_RESET = 1'b0;
    localparam logic [CNT_W-1:0] SEL_RESET = 5'h00;

    typedef enum logic [1:0] {SEQ_BOOT, SEQ_IDLE, SEQ_SAVE} seq_e;
endpackage : dpc_pkg
`default_nettype wire

// file: design/line_store.sv
// Simple dual-port line memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module line_store #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 512,
    parameter int AW = 9
) (
    input wire logic clk,               // Pixel clock
    input wire logic rdEn,              // Read strobe
    input wire logic [AW-1:0] rdAddr,   // Read address
    output logic [WIDTH-1:0] rdData,    // Read data, one cycle after rdEn
    input wire logic wrEn,              // Write strobe
    input wire logic [AW-1:0] wrAddr,   // Write address
    input wire logic [WIDTH-1:0] wrData // Write data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule : line_store
`default_nettype wire

// file: design/defective_pixel_corrector.sv
// Defective pixel corrector: table and outlier correction with APB control
`timescale 1ns/100ps
`default_nettype none
// Contract
// RL1: With table_correct_en set, listed pixels are replaced; clear, they pass unchanged.
// RL2: outlier_correct_en switches outlier correction, independent of the table enable.
// RL3: replace_method_sel exists; averaging is its only legal value.
// RL4: Averaging outputs the mean of the pixel's neighbours instead of it.
// RL5: Outliers against the 5x5 neighbourhood are corrected, both bright and dark.
// RL6: table_entry_count sets how many table entries take part in correction.
// RL7: table_entry_sel picks the entry that the coordinate controls address.
// RL8: Software indexes from zero up to the entry count minus one.
// RL9: entry_column and entry_row read and write the selected entry.
// RL10: Edits stay in the staged table until table_commit_cmd.
// RL11: table_commit_cmd copies the whole staged table into the active table.
// RL12: The active table is volatile and is lost without power.
// RL13: table_persist_cmd overwrites the stored table in non-volatile storage.
// RL14: At power-up the stored table is loaded before frames are corrected.
// RL15: Coordinates count from the full sensor image origin, not the crop window.
// RL16: Coordinate writes with the index at or past the count are ignored.
module defective_pixel_corrector import dpc_pkg::*; #(
    parameter int LINE_W = 512
) (
    input wire logic clk,                     // Pixel clock, 100 MHz
    input wire logic rst_b,                   // Asynchronous reset, active low
    input wire logic [ADDR_W-1:0] paddr,      // APB address
    input wire logic psel,                    // APB select
    input wire logic penable,                 // APB enable
    input wire logic pwrite,                  // APB direction
    input wire logic [31:0] pwdata,           // APB write data
    output logic [31:0] prdata,               // APB read data
    output logic pready,                      // APB ready
    output logic pslverr,                     // APB error on unmapped address
    input wire logic pixValid,                // Input pixel strobe
    input wire logic pixSof,                  // First pixel of a frame
    input wire logic [PIX_W-1:0] pixData,     // Input pixel value
    output logic outValid,                    // Output pixel strobe
    output logic [PIX_W-1:0] outData,         // Corrected pixel value
    output logic [CNT_W-1:0] nvAddr,          // Non-volatile word address
    output logic nvWrite,                     // Non-volatile write strobe
    output logic [NV_W-1:0] nvWrData,         // Non-volatile write data
    input wire logic [NV_W-1:0] nvRdData      // Non-volatile read data
);
    localparam int AW = $clog2(LINE_W);

    logic [COORD_W-1:0] colCnt, rowCnt;
    logic s1Valid;
    logic [PIX_W-1:0] s1Pix;
    logic [COORD_W-1:0] s1Col, s1Row;
    logic [LB_ROWS*PIX_W-1:0] lbRd;
    logic [PIX_W-1:0] colVec [WIN];
    logic [PIX_W-1:0] win [WIN][WIN];
    logic cValid;
    logic [COORD_W-1:0] cCol, cRow;
    logic [PIX_W-1:0] maxN, minN;
    logic [PIX_W+2:0] nearSum;
    logic [MAX_ENTRIES-1:0] hit;
    logic tableEn, outlierEn;
    logic [METHOD_W-1:0] replaceMethod;
    logic [CNT_W-1:0] entrySel;
    logic [CNT_W-1:0] stageCount, activeCount;
    logic [COORD_W-1:0] stageCol [MAX_ENTRIES];
    logic [COORD_W-1:0] stageRow [MAX_ENTRIES];
    logic [COORD_W-1:0] activeCol [MAX_ENTRIES];
    logic [COORD_W-1:0] activeRow [MAX_ENTRIES];
    seq_e seqState;
    logic [CNT_W-1:0] seqIdx;
    logic capValid;
    logic [CNT_W-1:0] capAddr;
    logic [31:0] readValue;

    // Pixel position, counted from the full image origin
    wire [COORD_W-1:0] curCol = pixSof ? '0 : colCnt;
    wire [COORD_W-1:0] curRow = pixSof ? '0 : rowCnt;
    wire lineEnd = curCol == COORD_W'(LINE_W - 1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            colCnt <= '0;
            rowCnt <= '0;
        end else if (pixValid) begin
            colCnt <= lineEnd ? '0 : curCol + 1'b1;  // see RL15
            rowCnt <= lineEnd ? curRow + 1'b1 : curRow;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1Valid <= 1'b0;
            s1Pix <= '0;
            s1Col <= '0;
            s1Row <= '0;
        end else begin
            s1Valid <= pixValid;
            if (pixValid) begin
                s1Pix <= pixData;
                s1Col <= curCol;
                s1Row <= curRow;
            end
        end
    end

    // Four previous lines, newest in the low slot
    line_store #(.WIDTH(LB_ROWS * PIX_W), .DEPTH(LINE_W), .AW(AW)) u_lines (
        .clk(clk),
        .rdEn(pixValid),
        .rdAddr(curCol[AW-1:0]),
        .rdData(lbRd),
        .wrEn(s1Valid),
        .wrAddr(s1Col[AW-1:0]),
        .wrData({lbRd[(LB_ROWS-1)*PIX_W-1:0], s1Pix})
    );

    // Column of the window; rows above the frame top repeat the row below
    generate
        for (genvar i = 0; i < WIN; i++) begin : g_vec
            if (i == 0) begin : g_cur
                assign colVec[i] = s1Pix;
            end else begin : g_old
                assign colVec[i] = (s1Row >= COORD_W'(i)) ? lbRd[(i-1)*PIX_W +: PIX_W] : colVec[i-1];
            end
        end
        for (genvar i = 0; i < WIN; i++) begin : g_row
            for (genvar j = 0; j < WIN; j++) begin : g_col
                always_ff @(posedge clk or negedge rst_b) begin
                    if (!rst_b) begin
                        win[i][j] <= '0;
                    end else if (s1Valid) begin
                        win[i][j] <= (j == 0) ? colVec[i] : win[i][(j == 0) ? 0 : j - 1];
                    end
                end
            end
        end
    endgenerate

    // Window centre trails the newest pixel by two rows and two columns
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cValid <= 1'b0;
            cCol <= '0;
            cRow <= '0;
        end else begin
            cValid <= s1Valid && s1Col >= WIN_MID && s1Row >= WIN_MID;
            if (s1Valid) begin
                cCol <= s1Col - WIN_MID;  // see RL15
                cRow <= s1Row - WIN_MID;
            end
        end
    end

    wire [PIX_W-1:0] centre = win[WIN_C][WIN_C];

    // Extremes of the 24 neighbours and sum of the 8 nearest
    always_comb begin
        maxN = '0;
        minN = '1;
        nearSum = '0;
        for (int i = 0; i < WIN; i++) begin
            for (int j = 0; j < WIN; j++) begin
                if (!(i == WIN_C && j == WIN_C)) begin
                    if (win[i][j] > maxN) begin
                        maxN = win[i][j];  // see RL5
                    end
                    if (win[i][j] < minN) begin
                        minN = win[i][j];
                    end
                    if (i >= WIN_C - 1 && i <= WIN_C + 1 && j >= WIN_C - 1 && j <= WIN_C + 1) begin
                        nearSum = nearSum + (PIX_W+3)'(win[i][j]);  // see RL4
                    end
                end
            end
        end
    end

    wire [PIX_W-1:0] avgNear = nearSum[PIX_W+2:3];

    generate
        for (genvar e = 0; e < MAX_ENTRIES; e++) begin : g_match
            assign hit[e] = (CNT_W'(e) < activeCount) && activeCol[e] == cCol && activeRow[e] == cRow;  // see RL6
        end
    endgenerate

    wire tableHit = |hit;
    wire staticFix = tableEn && tableHit && replaceMethod == METHOD_AVERAGE;  // see RL1
    wire hotPix = centre > maxN;
    wire coldPix = centre < minN;
    wire dynFix = outlierEn && (hotPix || coldPix);  // see RL2
    wire [PIX_W-1:0] dynValue = hotPix ? maxN : minN;
    wire [PIX_W-1:0] next_outData = staticFix ? avgNear : (dynFix ? dynValue : centre);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            outValid <= 1'b0;
            outData <= '0;
        end else begin
            outValid <= cValid;
            if (cValid) begin
                outData <= next_outData;
            end
        end
    end

    // APB slave, no wait states
    wire access = psel && penable;
    wire selCtrl = paddr == CTRL_OFS;
    wire selCount = paddr == COUNT_OFS;
    wire selSel = paddr == SEL_OFS;
    wire selColumn = paddr == COLUMN_OFS;
    wire selRow = paddr == ROW_OFS;
    wire selCmd = paddr == CMD_OFS;
    wire selActive = paddr == ACTIVE_OFS;
    wire addrHit = selCtrl || selCount || selSel || selColumn || selRow || selCmd || selActive;
    wire regWrite = access && pwrite && addrHit;
    wire busy = seqState != SEQ_IDLE;
    wire commitGo = regWrite && selCmd && pwdata[CMD_COMMIT_BIT] && !busy;
    wire persistGo = regWrite && selCmd && pwdata[CMD_PERSIST_BIT] && !busy;
    wire selInRange = entrySel < stageCount;
    wire [SEL_W-1:0] selLow = entrySel[SEL_W-1:0];
    wire colWrite = regWrite && selColumn && !busy && selInRange;  // see RL16
    wire rowWrite = regWrite && selRow && !busy && selInRange;  // see RL16
    wire countOk = pwdata[31:CNT_W] == '0 && pwdata[CNT_W-1:0] <= MAX_COUNT;
    wire countWrite = regWrite && selCount && !busy && countOk;
    wire methodOk = pwdata[METHOD_LSB +: METHOD_W] == METHOD_AVERAGE;
    wire [COORD_W-1:0] selCol = (entrySel < MAX_COUNT) ? stageCol[selLow] : '0;
    wire [COORD_W-1:0] selRowVal = (entrySel < MAX_COUNT) ? stageRow[selLow] : '0;

    assign pready = 1'b1;
    assign pslverr = access && !addrHit;

    always_comb begin
        readValue = '0;
        if (selCtrl) begin
            readValue[TABLE_EN_BIT] = tableEn;
            readValue[OUTLIER_EN_BIT] = outlierEn;
            readValue[METHOD_LSB +: METHOD_W] = replaceMethod;
        end else if (selCount) begin
            readValue[CNT_W-1:0] = stageCount;
        end else if (selSel) begin
            readValue[CNT_W-1:0] = entrySel;
        end else if (selColumn) begin
            readValue[COORD_W-1:0] = selCol;  // see RL9
        end else if (selRow) begin
            readValue[COORD_W-1:0] = selRowVal;  // see RL9
        end else if (selCmd) begin
            readValue[STAT_BUSY_BIT] = busy;
            readValue[STAT_LOADED_BIT] = seqState != SEQ_BOOT;
        end else if (selActive) begin
            readValue[CNT_W-1:0] = activeCount;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= readValue;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tableEn <= TABLE_EN_RESET;
            outlierEn <= OUTLIER_EN_RESET;
            replaceMethod <= METHOD_AVERAGE;
            entrySel <= SEL_RESET;
        end else if (regWrite && selCtrl) begin
            tableEn <= pwdata[TABLE_EN_BIT];
            outlierEn <= pwdata[OUTLIER_EN_BIT];
            if (methodOk) begin
                replaceMethod <= pwdata[METHOD_LSB +: METHOD_W];  // see RL3
            end
        end else if (regWrite && selSel) begin
            entrySel <= pwdata[CNT_W-1:0];  // see RL7
        end
    end

    // Stored count word, clamped to the table size
    wire capBig = nvRdData[NV_W-1:CNT_W] != '0 || nvRdData[CNT_W-1:0] > MAX_COUNT;
    wire [CNT_W-1:0] capCount = capBig ? MAX_COUNT : nvRdData[CNT_W-1:0];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stageCount <= '0;
            activeCount <= '0;
            for (int e = 0; e < MAX_ENTRIES; e++) begin
                stageCol[e] <= '0;
                stageRow[e] <= '0;
                activeCol[e] <= '0;  // see RL12
                activeRow[e] <= '0;
            end
        end else if (capValid) begin
            if (capAddr == NV_LAST) begin
                stageCount <= capCount;  // see RL14
                activeCount <= capCount;
            end else begin
                stageCol[capAddr[SEL_W-1:0]] <= nvRdData[COORD_W-1:0];
                stageRow[capAddr[SEL_W-1:0]] <= nvRdData[NV_W-1:COORD_W];
                activeCol[capAddr[SEL_W-1:0]] <= nvRdData[COORD_W-1:0];
                activeRow[capAddr[SEL_W-1:0]] <= nvRdData[NV_W-1:COORD_W];
            end
        end else if (commitGo) begin
            activeCount <= stageCount;  // see RL11
            for (int e = 0; e < MAX_ENTRIES; e++) begin
                activeCol[e] <= stageCol[e];
                activeRow[e] <= stageRow[e];
            end
        end else begin
            if (countWrite) begin
                stageCount <= pwdata[CNT_W-1:0];  // see RL6
            end
            if (colWrite) begin
                stageCol[selLow] <= pwdata[COORD_W-1:0];  // see RL10
            end
            if (rowWrite) begin
                stageRow[selLow] <= pwdata[COORD_W-1:0];  // see RL10
            end
        end
    end

    wire [NV_W-1:0] saveWord = (seqIdx == NV_LAST) ? NV_W'(stageCount)
                                                   : {stageRow[seqIdx[SEL_W-1:0]], stageCol[seqIdx[SEL_W-1:0]]};

    // Boot load and persist sequencer for the non-volatile table
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seqState <= SEQ_BOOT;
            seqIdx <= '0;
            nvAddr <= '0;
            nvWrite <= 1'b0;
            nvWrData <= '0;
            capValid <= 1'b0;
            capAddr <= '0;
        end else begin
            // Stop capturing once the count word is in, so no idle cycle is lost
            capValid <= seqState == SEQ_BOOT && !(capValid && capAddr == NV_LAST);
            capAddr <= nvAddr;
            case (seqState)
                SEQ_BOOT: begin
                    if (nvAddr != NV_LAST) begin
                        nvAddr <= nvAddr + 1'b1;  // see RL14
                    end
                    if (capValid && capAddr == NV_LAST) begin
                        seqState <= SEQ_IDLE;
                    end
                end
                SEQ_IDLE: begin
                    nvWrite <= 1'b0;
                    if (persistGo) begin
                        seqState <= SEQ_SAVE;
                        seqIdx <= '0;
                    end
                end
                SEQ_SAVE: begin
                    nvWrite <= 1'b1;  // see RL13
                    nvAddr <= seqIdx;
                    nvWrData <= saveWord;
                    seqIdx <= seqIdx + 1'b1;
                    if (seqIdx == NV_LAST) begin
                        seqState <= SEQ_IDLE;
                    end
                end
                default: begin
                    seqState <= SEQ_IDLE;
                end
            endcase
        end
    end

    property p_table_pass;
        @(posedge clk) disable iff (!rst_b)
        cValid && !tableEn && !outlierEn |=> outValid && outData == $past(centre);
    endproperty
    a_table_pass: assert property (p_table_pass) else $error("pixel altered with both corrections off"); // see RL1

    property p_static_avg;
        @(posedge clk) disable iff (!rst_b)
        cValid && tableEn && tableHit |=> outData == $past(avgNear);
    endproperty
    a_static_avg: assert property (p_static_avg) else $error("listed pixel not replaced by average"); // see RL4

    property p_dyn_off;
        @(posedge clk) disable iff (!rst_b)
        cValid && !outlierEn && !(tableEn && tableHit) |=> outData == $past(centre);
    endproperty
    a_dyn_off: assert property (p_dyn_off) else $error("outlier fix applied while disabled"); // see RL2

    property p_dyn_hot;
        @(posedge clk) disable iff (!rst_b)
        cValid && outlierEn && !staticFix && centre > maxN |=> outData == $past(maxN);
    endproperty
    a_dyn_hot: assert property (p_dyn_hot) else $error("bright outlier not clamped"); // see RL5

    property p_method;
        @(posedge clk) disable iff (!rst_b)
        regWrite && selCtrl |=> replaceMethod == METHOD_AVERAGE;
    endproperty
    a_method: assert property (p_method) else $error("illegal replacement method stored"); // see RL3

    property p_count_limit;
        @(posedge clk) disable iff (!rst_b)
        activeCount == '0 |-> !tableHit;
    endproperty
    a_count_limit: assert property (p_count_limit) else $error("match with empty active table"); // see RL6

    property p_ignore_write;
        @(posedge clk) disable iff (!rst_b)
        regWrite && selColumn && entrySel >= stageCount && !capValid |=> $stable(selCol);
    endproperty
    a_ignore_write: assert property (p_ignore_write) else $error("out-of-range coordinate write took effect"); // see RL16

    property p_staged_only;
        @(posedge clk) disable iff (!rst_b)
        (colWrite || rowWrite) && !capValid |=> $stable(activeCol[selLow]) && $stable(activeRow[selLow]);
    endproperty
    a_staged_only: assert property (p_staged_only) else $error("edit reached active table without commit"); // see RL10

    property p_commit;
        @(posedge clk) disable iff (!rst_b)
        commitGo && !capValid |=> activeCount == $past(stageCount) && activeCol[0] == $past(stageCol[0]);
    endproperty
    a_commit: assert property (p_commit) else $error("commit did not copy staged table"); // see RL11

    property p_persist;
        @(posedge clk) disable iff (!rst_b)
        persistGo |-> ##1 (seqState == SEQ_SAVE) ##17 (seqState == SEQ_IDLE);
    endproperty
    a_persist: assert property (p_persist) else $error("persist sequence length wrong"); // see RL13

    property p_boot;
        @(posedge clk) disable iff (!rst_b)
        seqState == SEQ_BOOT && capValid && capAddr == NV_LAST |=> seqState == SEQ_IDLE && activeCount == $past(capCount);
    endproperty
    a_boot: assert property (p_boot) else $error("boot load did not finish with stored count"); // see RL14
endmodule : defective_pixel_corrector
`default_nettype wire

// file: bench/nv_store_model.sv
// Non-volatile table storage with registered read
`timescale 1ns/100ps
`default_nettype none
module nv_store_model import dpc_pkg::*; (
    input wire logic clk,                // Pixel clock
    input wire logic [CNT_W-1:0] nvAddr, // Word address
    input wire logic nvWrite,            // Write strobe
    input wire logic [NV_W-1:0] nvWrData, // Write data
    output logic [NV_W-1:0] nvRdData     // Read data, one cycle after address
);
    logic [NV_W-1:0] mem [0:16];
    initial begin
        for (int i = 0; i <= 16; i++) begin
            mem[i] = 24'h000000;
        end
        // One stored entry at row 4, column 5
        mem[0] = {12'h004, 12'h005};
        mem[16] = 24'h000001;
    end
    always @(posedge clk) begin
        if (nvWrite) begin
            mem[nvAddr] <= nvWrData;
        end
        nvRdData <= mem[nvAddr];
    end
endmodule : nv_store_model
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the defective pixel corrector
`timescale 1ns/100ps
`default_nettype none
module tb_top import dpc_pkg::*;;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, pixValid = 1'b0, pixSof = 1'b0, outValid, nvWrite;
    logic [PIX_W-1:0] pixData = 10'h000, outData;
    logic [CNT_W-1:0] nvAddr;
    logic [NV_W-1:0] nvWrData, nvRdData;
    int n_errors = 0, comparisons = 0, cycles = 0, nonFlat = 0, d;
    always #5 clk = ~clk;
    defective_pixel_corrector #(.LINE_W(16)) i_dut (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pixValid(pixValid), .pixSof(pixSof), .pixData(pixData), .outValid(outValid),
        .outData(outData), .nvAddr(nvAddr), .nvWrite(nvWrite), .nvWrData(nvWrData), .nvRdData(nvRdData));
    nv_store_model i_nv (.clk(clk), .nvAddr(nvAddr), .nvWrite(nvWrite), .nvWrData(nvWrData),
        .nvRdData(nvRdData));
    always @(posedge clk) begin
        if (outValid === 1'b1 && outData !== 10'h064) begin
            nonFlat <= nonFlat + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict();
        end
    end
    task give_verdict;
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wait_idle;
        rd = 32'h1;
        for (int i = 0; i < 100 && rd[0] !== 1'b0; i++) begin
            apb(1'b0, CMD_OFS, 32'h0);
        end
    endtask : wait_idle
    task do_reset;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        wait_idle();
    endtask : do_reset
    // Ten rows of sixteen flat pixels with one odd pixel; d counts odd outputs
    task frame(input int oc, input int orow, input logic [9:0] ov);
        int base;
        base = nonFlat;
        for (int r = 0; r < 10; r++) begin
            for (int c = 0; c < 16; c++) begin
                @(posedge clk);
                pixValid <= 1'b1;
                pixSof <= (r == 0 && c == 0);
                pixData <= (r == orow && c == oc) ? ov : 10'h064;
            end
        end
        @(posedge clk);
        pixValid <= 1'b0;
        repeat (8) @(posedge clk);
        d = nonFlat - base;
    endtask : frame
    initial begin
        do_reset();
        chk(rd, 32'h2);
        apb(1'b0, ACTIVE_OFS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, CTRL_OFS, 32'h31);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        frame(0, 0, 10'h064);
        frame(5, 4, 10'h384);
        chk(d, 0);
        apb(1'b1, CTRL_OFS, 32'h0);
        frame(5, 4, 10'h384);
        chk(d, 1);
        apb(1'b1, CTRL_OFS, 32'h2);
        frame(7, 6, 10'h384);
        chk(d, 0);
        frame(7, 6, 10'h005);
        chk(d, 0);
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b1, COUNT_OFS, 32'h0);
        frame(5, 4, 10'h384);
        chk(d, 0);
        apb(1'b0, ACTIVE_OFS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, CMD_OFS, 32'h1);
        apb(1'b0, ACTIVE_OFS, 32'h0);
        chk(rd, 32'h0);
        frame(5, 4, 10'h384);
        chk(d, 1);
        apb(1'b1, COUNT_OFS, 32'h2);
        apb(1'b1, SEL_OFS, 32'h1);
        apb(1'b1, COLUMN_OFS, 32'h7);
        apb(1'b1, ROW_OFS, 32'h6);
        apb(1'b0, COLUMN_OFS, 32'h0);
        chk(rd, 32'h7);
        apb(1'b1, SEL_OFS, 32'h2);
        apb(1'b1, COLUMN_OFS, 32'hab);
        apb(1'b0, COLUMN_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, CMD_OFS, 32'h2);
        wait_idle();
        chk({8'h00, i_nv.mem[16]}, 32'h2);
        chk({8'h00, i_nv.mem[1]}, 32'h6007);
        do_reset();
        apb(1'b0, ACTIVE_OFS, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, CTRL_OFS, 32'h1);
        frame(7, 6, 10'h384);
        chk(d, 0);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
